// [smt_evt_select.sv]
// event source and one-shot trigger selection for one timer channel
// assumes neighbouring overflows arrive as one-cycle strobes on mclk_i
`timescale 1ns/1ps
`default_nettype none
module smt_evt_select (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       srst_i,
   // selections
   input  wire logic [1:0] evt_src_sel_i,
   input  wire logic [1:0] trig_sel_i,
   input  wire logic       oneshot_start_i,
   // overflow strobes from other timers
   input  wire logic       second_group_timer_overflow_i,
   input  wire logic       neighbour_timer_low_i,
   input  wire logic       neighbour_timer_high_i,
   // selected strobes
   output logic            evt_o,
   output logic            trig_o
);
   logic src_w;  // selected overflow strobe
   logic trg_w;  // selected trigger strobe

   assign src_w = (evt_src_sel_i == smt_pkg::ESRC_SECOND) ? second_group_timer_overflow_i :
                  (evt_src_sel_i == smt_pkg::ESRC_LOW)    ? neighbour_timer_low_i :
                  (evt_src_sel_i == smt_pkg::ESRC_HIGH)   ? neighbour_timer_high_i :
                  1'b0;
   // trigger is the software flag or one of the overflow strobes
   assign trg_w = (trig_sel_i == smt_pkg::TRIG_SW) ? oneshot_start_i :
                  (trig_sel_i == smt_pkg::ESRC_LOW) ? neighbour_timer_low_i :
                  (trig_sel_i == smt_pkg::ESRC_HIGH) ? neighbour_timer_high_i :
                  second_group_timer_overflow_i;

   // registered strobes
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         evt_o  <= 1'b0;
         trig_o <= 1'b0;
      end else begin
         evt_o  <= src_w;
         trig_o <= trg_w;
      end
   end
endmodule
`default_nettype wire

// [smt_pkg.sv]
// constants and types shared by the sixteen-bit multimode timer channel
// assumes a single 10 MHz clock and a synchronous active-high reset
package smt_pkg;
   // counter geometry
   localparam int          CNT_W       = 16;
   localparam logic [15:0] CNT_MAX     = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO    = 16'h0000;
   localparam logic [15:0] CNT_ONE     = 16'h0001;
   localparam logic [15:0] CNT_RST     = 16'h0000;
   // mode field codes, two low bits of the mode register
   localparam logic [1:0]  MODE_TIMER  = 2'h0;
   localparam logic [1:0]  MODE_EVENT  = 2'h1;
   localparam logic [1:0]  MODE_ONESHOT = 2'h2;
   // count source select codes
   localparam logic [1:0]  CSRC_DIV1   = 2'h0;
   localparam logic [1:0]  CSRC_DIV8   = 2'h1;
   localparam logic [1:0]  CSRC_DIV32  = 2'h2;
   localparam logic [1:0]  CSRC_SUB32  = 2'h3;
   // event source and one-shot trigger select codes
   localparam logic [1:0]  ESRC_SECOND = 2'h0;
   localparam logic [1:0]  ESRC_LOW    = 2'h1;
   localparam logic [1:0]  ESRC_HIGH   = 2'h2;
   localparam logic [1:0]  TRIG_SW     = 2'h0;
   // prescaler divide counts
   localparam int          DIV8_CNT    = 8;
   localparam int          DIV32_CNT   = 32;
   localparam int          PRE_W       = 5;
   // decoded operating mode
   typedef enum logic [1:0] {SMT_TIMER, SMT_EVENT, SMT_ONESHOT, SMT_IDLE} smt_mode_e;
endpackage

// [smt_prescaler.sv]
// prescaler: derives the internal count source ticks from the system clock
// assumes the sub-clock tap arrives as a one-cycle strobe synchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
module smt_prescaler (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       srst_i,
   // source selection
   input  wire logic [1:0] clk_sel_i,
   input  wire logic       subclock_div32_tap_i,
   // selected tick
   output logic            tick_o
);
   logic [smt_pkg::PRE_W-1:0] pre_r;   // free-running divider
   logic                      div8_w;  // every eighth clock
   logic                      div32_w; // every thirty-second clock
   logic                      sel_w;   // chosen source

   // a shared free divider keeps the divide-by-8 and divide-by-32 taps phase-aligned
   assign div8_w  = (pre_r[2:0] == 3'(smt_pkg::DIV8_CNT - 1));
   assign div32_w = (pre_r == smt_pkg::PRE_W'(smt_pkg::DIV32_CNT - 1));
   assign sel_w   = (clk_sel_i == smt_pkg::CSRC_DIV1)  ? 1'b1 :
                    (clk_sel_i == smt_pkg::CSRC_DIV8)  ? div8_w :
                    (clk_sel_i == smt_pkg::CSRC_DIV32) ? div32_w :
                    subclock_div32_tap_i;

   // divider and registered tick
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         pre_r  <= '0;
         tick_o <= 1'b0;
      end else begin
         pre_r  <= pre_r + smt_pkg::PRE_W'(1);
         tick_o <= sel_w;
      end
   end
endmodule
`default_nettype wire

// [smt_timer.sv]
// one sixteen-bit multimode timer channel: interval, event counter, one-shot
// assumes control bits are held by software registers outside, write and
// trigger strobes are one mclk_i cycle wide, and all inputs are synchronous
`timescale 1ns/1ps
`default_nettype none
module smt_timer #(
   parameter int CNT_W = smt_pkg::CNT_W      // counter width
) (
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             srst_i,
   // mode and source configuration
   input  wire logic [1:0]       mode_i,
   input  wire logic [1:0]       clk_sel_i,
   input  wire logic [1:0]       evt_src_sel_i,
   input  wire logic [1:0]       trig_sel_i,
   input  wire logic             free_run_i,
   input  wire logic             pulse_out_en_i,
   input  wire logic             dir_pin_sel_i,
   input  wire logic             up_flag_i,
   // control flags
   input  wire logic             run_i,
   input  wire logic             oneshot_start_i,
   // count register access
   input  wire logic             count_wr_i,
   input  wire logic [CNT_W-1:0] count_wdata_i,
   output logic      [CNT_W-1:0] count_rdata_o,
   // count sources
   input  wire logic             subclock_div32_tap_i,
   input  wire logic             second_group_timer_overflow_i,
   input  wire logic             neighbour_timer_low_i,
   input  wire logic             neighbour_timer_high_i,
   // channel pin, split into its three signals
   input  wire logic             channel_pulse_pin_i,
   output logic                  channel_pulse_pin_o,
   output logic                  channel_pulse_pin_oe_o,
   input  wire logic             gpio_out_i,
   input  wire logic             gpio_oe_i,
   // interrupt request
   output logic                  irq_o
);
   smt_pkg::smt_mode_e mode_w;      // decoded mode

   logic [CNT_W-1:0] cnt_r;         // live counter
   logic [CNT_W-1:0] cnt_nxt;
   logic [CNT_W-1:0] rld_r;         // reload register
   logic             active_r;      // one-shot in progress
   logic             active_nxt;
   logic             tog_r;         // pulse output level
   logic             tick_w;        // internal source tick
   logic             evt_w;         // event source strobe
   logic             trig_w;        // one-shot trigger strobe
   logic             up_w;          // event direction is up
   logic             running_w;     // counter considered running
   logic             at_max_w;
   logic             at_zero_w;
   logic             tmr_uf_w;      // interval underflow
   logic             evt_wrap_w;    // event over/underflow
   logic             os_end_w;      // one-shot reaches zero
   logic             os_trig_w;     // accepted one-shot trigger
   logic             irq_w;
   logic             pin_dir_in_w;  // pin used as direction input
   logic             pin_nxt;
   logic             oe_nxt;

   // internal prescaled count source
   smt_prescaler u_pre (
      .mclk_i               (mclk_i),
      .srst_i               (srst_i),
      .clk_sel_i            (clk_sel_i),
      .subclock_div32_tap_i (subclock_div32_tap_i),
      .tick_o               (tick_w)
   );

   // event source and trigger selection
   smt_evt_select u_sel (
      .mclk_i                        (mclk_i),
      .srst_i                        (srst_i),
      .evt_src_sel_i                 (evt_src_sel_i),
      .trig_sel_i                    (trig_sel_i),
      .oneshot_start_i               (oneshot_start_i),
      .second_group_timer_overflow_i (second_group_timer_overflow_i),
      .neighbour_timer_low_i         (neighbour_timer_low_i),
      .neighbour_timer_high_i        (neighbour_timer_high_i),
      .evt_o                         (evt_w),
      .trig_o                        (trig_w)
   );

   // mode decode from the two low mode bits
   assign mode_w = (mode_i == smt_pkg::MODE_TIMER)   ? smt_pkg::SMT_TIMER :
                   (mode_i == smt_pkg::MODE_EVENT)   ? smt_pkg::SMT_EVENT :
                   (mode_i == smt_pkg::MODE_ONESHOT) ? smt_pkg::SMT_ONESHOT :
                   smt_pkg::SMT_IDLE;   // unsupported mode parks the counter

   // direction: the pin only steers it when chosen as direction input
   assign pin_dir_in_w = (mode_w == smt_pkg::SMT_EVENT) && dir_pin_sel_i;
   assign up_w         = pin_dir_in_w ? channel_pulse_pin_i : up_flag_i;

   // one-shot runs only while armed; other modes follow the run flag
   assign running_w = (mode_w == smt_pkg::SMT_ONESHOT) ? active_r : run_i;

   assign at_max_w   = (cnt_r == smt_pkg::CNT_MAX);
   assign at_zero_w  = (cnt_r == smt_pkg::CNT_ZERO);
   assign tmr_uf_w   = (mode_w == smt_pkg::SMT_TIMER) && run_i && tick_w && at_zero_w;
   assign evt_wrap_w = (mode_w == smt_pkg::SMT_EVENT) && run_i && evt_w &&
                       (up_w ? at_max_w : at_zero_w);
   // n of zero ends after one tick rather than waiting a full wrap
   assign os_end_w   = (mode_w == smt_pkg::SMT_ONESHOT) && active_r && run_i && tick_w &&
                       (cnt_r <= smt_pkg::CNT_ONE);
   // trigger is accepted only with the run flag set
   assign os_trig_w  = (mode_w == smt_pkg::SMT_ONESHOT) && run_i && trig_w;
   assign irq_w      = tmr_uf_w || evt_wrap_w || os_end_w;

   // counter next value; a write never races a count in the same cycle
   always_comb begin
      cnt_nxt    = cnt_r;
      active_nxt = active_r;
      if (count_wr_i && !running_w) begin
         cnt_nxt = count_wdata_i;
      end else begin
         case (mode_w)
            smt_pkg::SMT_TIMER: begin
               if (run_i && tick_w) begin
                  // underflow reload continues counting
                  cnt_nxt = at_zero_w ? rld_r : cnt_r - CNT_W'(1);
               end
            end
            smt_pkg::SMT_EVENT: begin
               if (run_i && evt_w) begin
                  if (evt_wrap_w && !free_run_i) begin
                     cnt_nxt = rld_r;
                  end else if (up_w) begin
                     cnt_nxt = cnt_r + CNT_W'(1);
                  end else begin
                     cnt_nxt = cnt_r - CNT_W'(1);
                  end
               end
            end
            smt_pkg::SMT_ONESHOT: begin
               if (!run_i) begin
                  active_nxt = 1'b0;
               end else if (os_trig_w) begin
                  cnt_nxt    = rld_r;
                  active_nxt = 1'b1;
               end else if (os_end_w) begin
                  cnt_nxt    = rld_r;
                  active_nxt = 1'b0;
               end else if (active_r && tick_w) begin
                  cnt_nxt = cnt_r - CNT_W'(1);
               end
            end
            default: begin
               active_nxt = 1'b0;
            end
         endcase
      end
   end

   // counter, reload register and one-shot state
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         cnt_r    <= smt_pkg::CNT_RST;
         rld_r    <= smt_pkg::CNT_RST;
         active_r <= 1'b0;
      end else begin
         cnt_r    <= cnt_nxt;
         active_r <= active_nxt;
         if (count_wr_i) begin
            rld_r <= count_wdata_i;          // running writes land here only
         end
      end
   end

   // pulse output level toggles on every counter wrap
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         tog_r <= 1'b0;
      end else if (tmr_uf_w || evt_wrap_w) begin
         tog_r <= ~tog_r;
      end
   end

   // pin drive: pulse output, direction input, or general-purpose port
   always_comb begin
      pin_nxt = gpio_out_i;
      oe_nxt  = gpio_oe_i;
      if (pin_dir_in_w) begin
         pin_nxt = 1'b0;
         oe_nxt  = 1'b0;
      end else if (pulse_out_en_i && (mode_w == smt_pkg::SMT_ONESHOT)) begin
         pin_nxt = active_nxt;       // high while the one-shot runs
         oe_nxt  = 1'b1;
      end else if (pulse_out_en_i && (mode_w != smt_pkg::SMT_IDLE)) begin
         // toggled value shown alongside the wrap that caused it
         pin_nxt = (tmr_uf_w || evt_wrap_w) ? ~tog_r : tog_r;
         oe_nxt  = 1'b1;
      end
   end

   // registered outputs
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         irq_o                  <= 1'b0;
         channel_pulse_pin_o    <= 1'b0;
         channel_pulse_pin_oe_o <= 1'b0;
      end else begin
         irq_o                  <= irq_w;
         channel_pulse_pin_o    <= pin_nxt;
         channel_pulse_pin_oe_o <= oe_nxt;
      end
   end

   // live count; contents are meaningless in one-shot mode
   assign count_rdata_o = cnt_r;
endmodule
`default_nettype wire

// [smt_timer_asserts.sv]
// port-level timing checks for one timer channel
// assumes it is bound onto smt_timer, one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module smt_timer_asserts #(
   parameter int CNT_W = 16
) (
   // watched ports of the channel
   input wire logic             mclk_i,
   input wire logic             srst_i,
   input wire logic [1:0]       mode_i,
   input wire logic [1:0]       clk_sel_i,
   input wire logic [1:0]       evt_src_sel_i,
   input wire logic             free_run_i,
   input wire logic             pulse_out_en_i,
   input wire logic             dir_pin_sel_i,
   input wire logic             up_flag_i,
   input wire logic             run_i,
   input wire logic             count_wr_i,
   input wire logic [CNT_W-1:0] count_wdata_i,
   input wire logic [CNT_W-1:0] count_rdata_o,
   input wire logic             second_group_timer_overflow_i,
   input wire logic             channel_pulse_pin_o,
   input wire logic             irq_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   logic [CNT_W-1:0] rl_r;   // mirror of the reload value, any write lands here
   // the mirror lets wrap checks know the reload without peeking inside
   always_ff @(posedge mclk_i)
      if (srst_i) rl_r <= '0;
      else if (count_wr_i) rl_r <= count_wdata_i;
   // interval mode running on the undivided clock
   wire tmr_w = mode_i == smt_pkg::MODE_TIMER && run_i && clk_sel_i == smt_pkg::CSRC_DIV1;
   // event mode running, software direction, counting the second-group strobe
   wire evt_w = mode_i == smt_pkg::MODE_EVENT && run_i && !count_wr_i && !dir_pin_sel_i
      && evt_src_sel_i == smt_pkg::ESRC_SECOND;
   // a strobe taken now is counted one edge later
   sequence s_strobe(logic up);
      evt_w && up_flag_i == up && second_group_timer_overflow_i;
   endsequence
   property p_halt;
      mode_i == smt_pkg::MODE_TIMER && !run_i && !count_wr_i |=> $stable(count_rdata_o);
   endproperty
   property p_wr_halt;
      count_wr_i && !run_i && !mode_i[1] |=> count_rdata_o == $past(count_wdata_i);
   endproperty
   property p_tmr_dec;
      tmr_w && $past(tmr_w) && $past(tmr_w, 2) && count_rdata_o != '0
         |=> count_rdata_o == $past(count_rdata_o) - 1'b1;
   endproperty
   property p_tmr_wrap;
      tmr_w && $past(tmr_w) && $past(tmr_w, 2) && !count_wr_i && count_rdata_o == '0
         |=> irq_o && count_rdata_o == rl_r;
   endproperty
   property p_irq_pulse;
      irq_o |=> !irq_o;
   endproperty
   property p_pin;
      irq_o && pulse_out_en_i && $past(pulse_out_en_i) && mode_i == smt_pkg::MODE_TIMER
         |-> channel_pulse_pin_o != $past(channel_pulse_pin_o);
   endproperty
   property p_evt_down;
      s_strobe(1'b0) ##1 (evt_w && !up_flag_i && count_rdata_o != '0)
         |=> count_rdata_o == $past(count_rdata_o) - 1'b1;
   endproperty
   property p_evt_wrap;
      s_strobe(1'b1) ##1 (evt_w && up_flag_i && !free_run_i && count_rdata_o == '1)
         |=> irq_o && count_rdata_o == rl_r;
   endproperty
   a_halt: assert property (p_halt) else $error("count moved while halted");
   a_wr_halt: assert property (p_wr_halt) else $error("halted write lost");
   a_tmr_dec: assert property (p_tmr_dec) else $error("interval step wrong");
   a_tmr_wrap: assert property (p_tmr_wrap) else $error("underflow wrong");
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
   a_pin: assert property (p_pin) else $error("pin did not toggle");
   a_evt_down: assert property (p_evt_down) else $error("event step wrong");
   a_evt_wrap: assert property (p_evt_wrap) else $error("overflow wrong");
endmodule
bind smt_timer smt_timer_asserts #(.CNT_W(CNT_W)) smt_timer_asserts_i (
   .mclk_i(mclk_i), .srst_i(srst_i), .mode_i(mode_i), .clk_sel_i(clk_sel_i),
   .evt_src_sel_i(evt_src_sel_i), .free_run_i(free_run_i), .pulse_out_en_i(pulse_out_en_i),
   .dir_pin_sel_i(dir_pin_sel_i), .up_flag_i(up_flag_i), .run_i(run_i),
   .count_wr_i(count_wr_i), .count_wdata_i(count_wdata_i), .count_rdata_o(count_rdata_o),
   .second_group_timer_overflow_i(second_group_timer_overflow_i),
   .channel_pulse_pin_o(channel_pulse_pin_o), .irq_o(irq_o));
`default_nettype wire

// [tb_top.sv]
// self-checking bench for one timer channel: interval, event, one-shot
// assumes the checker is bound to the channel; one 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic mclk_i, srst_i;         // system clock; reset held for the first 16 cycles
   logic [1:0] mode_i, clk_sel_i, evt_src_sel_i, trig_sel_i;
   logic free_run_i, pulse_out_en_i, dir_pin_sel_i, up_flag_i;
   logic run_i, oneshot_start_i, count_wr_i, pin_in, gpio_oe;
   logic [15:0] count_wdata_i, count_rdata_o;
   logic sub_tap, sec_ovf, nb_lo, nb_hi, gpio_out;
   logic pin_o, pin_oe, irq_o;   // channel outputs
   logic evt_on = 1'b0;          // selected event source fires every cycle
   logic quiet = 1'b0;           // silences random strobes for overflow triggers
   logic [31:0] rnd;             // random traffic word
   int seed = 32'h73E4;
   int fail_count = 0, comparisons = 0, cyc = 0;
   logic [15:0] exp_q[$];        // one note per expected interrupt

   always #50 mclk_i = ~mclk_i;

   smt_timer #(.CNT_W(16)) smt_timer_i (
      .mclk_i(mclk_i), .srst_i(srst_i), .mode_i(mode_i), .clk_sel_i(clk_sel_i),
      .evt_src_sel_i(evt_src_sel_i), .trig_sel_i(trig_sel_i), .free_run_i(free_run_i),
      .pulse_out_en_i(pulse_out_en_i), .dir_pin_sel_i(dir_pin_sel_i), .up_flag_i(up_flag_i),
      .run_i(run_i), .oneshot_start_i(oneshot_start_i), .count_wr_i(count_wr_i),
      .count_wdata_i(count_wdata_i), .count_rdata_o(count_rdata_o),
      .subclock_div32_tap_i(sub_tap), .second_group_timer_overflow_i(sec_ovf),
      .neighbour_timer_low_i(nb_lo), .neighbour_timer_high_i(nb_hi),
      .channel_pulse_pin_i(pin_in), .channel_pulse_pin_o(pin_o),
      .channel_pulse_pin_oe_o(pin_oe), .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .irq_o(irq_o));

   // unselected sources stay random so a wrong source select shows up
   always @(posedge mclk_i) begin
      #1;
      cyc++;
      rnd = $random(seed);
      sec_ovf = (rnd[0] & !quiet) | (evt_on && evt_src_sel_i == smt_pkg::ESRC_SECOND);
      nb_lo = (rnd[1] & !quiet) | (evt_on && evt_src_sel_i == smt_pkg::ESRC_LOW);
      nb_hi = (rnd[2] & !quiet) | (evt_on && evt_src_sel_i == smt_pkg::ESRC_HIGH);
      gpio_out = rnd[3];
      sub_tap = (cyc % 4 == 0);
   end

   // each interrupt takes the oldest note; one-shot counts are not meaningful
   always @(posedge mclk_i) begin
      if (!srst_i && irq_o === 1'b1) begin
         if (exp_q.size() == 0) check(16'h0001, 16'h0000);
         else if (mode_i == smt_pkg::MODE_ONESHOT) exp_q.delete(0);
         else check(count_rdata_o, exp_q.pop_front());
      end
   end

   task check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task test_done;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   // one-cycle write strobe
   task wr(input logic [15:0] v);
      count_wr_i = 1'b1;
      count_wdata_i = v;
      tick(1);
      count_wr_i = 1'b0;
   endtask

   // cycles from the call to the interrupt cycle; bounded so a dead timer ends the run
   task wait_irq(output int n);
      n = 0;
      do begin
         tick(1);
         n++;
      end while (irq_o !== 1'b1 && n < 5000);
      if (n >= 5000) begin
         fail_count++;
         test_done();
      end
   endtask

   // fire a shot, optional retrigger at re and run clear at st; count pin-high cycles
   task os_run(input int re, input int st, output int hi);
      hi = 0;
      for (int i = 0; i < 16; i++) begin
         oneshot_start_i = (i == 0 || i == re);
         if (i == st) run_i = 1'b0;
         tick(1);
         hi += int'(pin_o === 1'b1);
      end
      run_i = 1'b1;
   endtask

   initial begin : main
      int p, n, r;
      logic p0;
      logic [15:0] v;
      {mclk_i, mode_i, clk_sel_i, evt_src_sel_i, trig_sel_i} = '0;
      {free_run_i, dir_pin_sel_i, up_flag_i, run_i, oneshot_start_i} = '0;
      {count_wr_i, pin_in, gpio_oe, count_wdata_i} = '0;
      {sub_tap, sec_ovf, nb_lo, nb_hi, gpio_out} = '0;
      srst_i = 1'b1;
      pulse_out_en_i = 1'b1;
      tick(16);
      srst_i = 1'b0;
      // interval on the undivided clock
      wr(16'h0002);
      check(count_rdata_o, 16'h0002);
      run_i = 1'b1;
      exp_q.push_back(16'h0002);
      wait_irq(p);
      p0 = pin_o;
      exp_q.push_back(16'h0002);
      wait_irq(p);
      check(16'(p), 16'h0003);
      check(pin_o, !p0);
      // running write: old reload still finishes this period (write used a cycle)
      wr(16'h0005);
      exp_q.push_back(16'h0005);
      wait_irq(p);
      check(16'(p), 16'h0002);
      exp_q.push_back(16'h0005);
      wait_irq(p);
      check(16'(p), 16'h0006);
      tick(1);
      check(count_rdata_o, 16'h0004);
      run_i = 1'b0;
      tick(2);
      v = count_rdata_o;
      tick(5);
      check(count_rdata_o, v);
      // prescaled taps and the sub-clock strobe (every 4 cycles), n = 1
      for (int s = 1; s < 4; s++) begin
         wr(16'h0001);
         clk_sel_i = 2'(s);
         run_i = 1'b1;
         exp_q.push_back(16'h0001);
         wait_irq(p);
         exp_q.push_back(16'h0001);
         wait_irq(p);
         check(16'(p), 16'(s == 1 ? 16 : s == 2 ? 64 : 8));
         run_i = 1'b0;
      end
      // event counter: every source, both directions, by flag and by pin
      mode_i = smt_pkg::MODE_EVENT;
      for (int k = 0; k < 4; k++) begin
         r = 2 + ($random(seed) & 7);
         evt_src_sel_i = 2'(k < 2 ? 0 : k - 1);
         dir_pin_sel_i = k[1];
         pin_in = k[0];
         up_flag_i = k[1] ^ k[0];   // flag opposes the pin when the pin decides
         v = k[0] ? 16'hFFFF - 16'(r) : 16'(r);
         wr(v);
         run_i = 1'b1;
         evt_on = 1'b1;
         exp_q.push_back(v);
         wait_irq(p);
         p0 = pin_o;
         exp_q.push_back(v);
         wait_irq(p);
         check(16'(p), 16'(r + 1));
         if (k < 2) check(pin_o, !p0);
         else check(pin_oe, 1'b0);
         run_i = 1'b0;
         evt_on = 1'b0;
      end
      // free-run wraps through the end of the range instead of reloading
      free_run_i = 1'b1;
      dir_pin_sel_i = 1'b0;
      for (int k = 0; k < 2; k++) begin
         up_flag_i = k[0];
         wr(k[0] ? 16'hFFFE : 16'h0001);
         run_i = 1'b1;
         evt_on = 1'b1;
         exp_q.push_back(k[0] ? 16'h0000 : 16'hFFFF);
         wait_irq(p);
         run_i = 1'b0;
         evt_on = 1'b0;
      end
      free_run_i = 1'b0;
      // one-shot: plain shot, retrigger, and stop by clearing run
      mode_i = smt_pkg::MODE_ONESHOT;
      clk_sel_i = smt_pkg::CSRC_DIV1;
      wr(16'h0003);
      run_i = 1'b1;
      exp_q.push_back(16'h0000);
      os_run(-1, -1, n);
      check(16'(n), 16'h0003);
      exp_q.push_back(16'h0000);
      os_run(2, -1, n);
      check(16'(n), 16'h0005);
      os_run(-1, 2, n);
      check(16'(n < 3), 16'h0001);
      // trigger from the second-group overflow instead of the software flag
      quiet = 1'b1;
      trig_sel_i = 2'h3;
      evt_src_sel_i = smt_pkg::ESRC_SECOND;
      exp_q.push_back(16'h0000);
      tick(2);
      evt_on = 1'b1;
      tick(1);
      evt_on = 1'b0;
      n = 0;
      repeat (12) begin
         tick(1);
         n += int'(pin_o === 1'b1);
      end
      check(16'(n), 16'h0003);
      // pulse output off: the pin falls back to the general-purpose enable
      pulse_out_en_i = 1'b0;
      gpio_oe = 1'b1;
      tick(2);
      check(16'(pin_oe), 16'h0001);
      check(16'(exp_q.size()), 16'h0000);
      test_done();
   end
endmodule
`default_nettype wire
